// ==== rtl/lbs_sequencer.sv ====
// lcd bias supply startup sequencer with wishbone registers
// Notes on behaviour
// - buck rail follows buck enable and undervoltage lockout only, whatever bias enable does.
// - bias enable turns both negative rails on in the same cycle.
// - boost rail starts after the first delay; positive gate rail uses the second.
// - positive gate rail never starts before the first delay has run out.
// - delays end at their threshold count; zero count means zero delay.
// - power good released only when boost and positive gate rails regulate.
// - power good is open drain, driven low or released, never high.
// - released power good stays latched until a rail short is seen or the sequencer leaves run.
// - isolation gate drive goes low once boost enabled and first delay passed.
// - isolation gate drive returns high whenever the sequencer leaves run, not when a gate rail short stops boost.
// - boost feedback low beyond the short time latches boost off, gate high.
// - short latch-off holds until an enable toggles or undervoltage occurs.
// - stress-test select high pulls the stress resistor pin to ground.
// - overvoltage sense stops boost switching.
// - boost feedback over-level stops boost switching.
// - switching resumes by itself once the overvoltage clears.
// - boost switching clock is a fixed 750 kHz pulse train.
// - boost current limit ramps up until regulation or maximum.
// - positive gate rail short disables boost, except after the rail passed threshold and before it regulated.
// - buck short shuts all other rails as if bias were off, then restarts; in short latch-off the sequencer stays latched; only negative rails return.
// - undervoltage lockout holds all rails off and the isolation gate drive high.
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module lbs_sequencer #(
  parameter int unsigned SHORT_CYC = lbs_pkg::SHORT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // comparator and pin inputs
  input wire lbs_pkg::lbs_sense_t sense_i,
  // rail enables and converter drive
  output lbs_pkg::lbs_rails_t rails_o,
  output logic boost_switch_o,
  output logic [lbs_pkg::ILIM_W-1:0] current_limit_o,
  output logic isolation_gate_drive_o,
  // open-drain pins
  output logic power_good_out_o,
  output logic power_good_out_oe_n_o,
  output logic stress_resistor_switch_o,
  output logic stress_resistor_switch_oe_n_o
);
  // byte-lane merge for register writes
  function automatic logic [lbs_pkg::CNT_W-1:0] lane_merge(
    input logic [lbs_pkg::CNT_W-1:0] old_v,
    input logic [31:0] wr_v,
    input logic [3:0] sel_v
  );
    logic [31:0] r;
    r = {12'h000, old_v};
    for (int i = 0; i < 4; i++)
    begin
      if (sel_v[i])
        r[8*i +: 8] = wr_v[8*i +: 8];
    end
    return r[lbs_pkg::CNT_W-1:0];
  endfunction

  lbs_pkg::lbs_sense_t s;
  lbs_pkg::lbs_state_t state;
  lbs_pkg::lbs_state_t next_state;
  lbs_pkg::lbs_rails_t next_rails;
  logic [lbs_pkg::CNT_W-1:0] boost_delay;
  logic [lbs_pkg::CNT_W-1:0] pos_gate_delay;
  logic [lbs_pkg::CNT_W-1:0] ss_step;
  logic [lbs_pkg::CNT_W-1:0] ss_count;
  logic [6:0] pwm_count;
  logic bias_ok;
  logic seq_run;
  logic boost_wait_done;
  logic gate_wait_done;
  logic short_done;
  logic pos_en;
  logic pump_passed;
  logic pump_armed;
  logic pump_block;
  logic boost_on;
  logic good_latched;
  logic ss_done;
  logic wb_req;
  logic [31:0] status_word;
  logic [31:0] read_word;

  // pin levels cross into the clock domain
  lbs_sync #(
    .W($bits(lbs_pkg::lbs_sense_t))
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sense_i),
    .q_o(s)
  );

  // bias rails may run: enable high, no lockout, no buck short
  // buck short acts as bias off
  assign bias_ok = s.bias_enable_in && !s.uvlo && !s.buck_short;

  // startup sequence
  always_comb
  begin
    next_state = state;
    case (state)
      lbs_pkg::ST_OFF:
        if (bias_ok)
          next_state = lbs_pkg::ST_DELAY;
      lbs_pkg::ST_DELAY:
        if (!bias_ok)
          next_state = lbs_pkg::ST_OFF;
        else if (boost_wait_done)
          next_state = lbs_pkg::ST_RUN;
      lbs_pkg::ST_RUN:
        if (!bias_ok)
          next_state = lbs_pkg::ST_OFF;
        else if (short_done)
          next_state = lbs_pkg::ST_LATCH;
      // leave only on enable or lockout
      lbs_pkg::ST_LATCH:
        if (!s.bias_enable_in || !s.buck_enable_in || s.uvlo)
          next_state = lbs_pkg::ST_OFF;
      default:
        next_state = lbs_pkg::ST_OFF;
    endcase
  end

  // state register
  // reset clears sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= lbs_pkg::ST_OFF;
    else
      state <= next_state;
  end

  // both delays time from bias enable
  assign seq_run = (state == lbs_pkg::ST_DELAY) || (state == lbs_pkg::ST_RUN);

  lbs_interval u_boost_wait (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(seq_run),
    .limit_i(boost_delay),
    .done_o(boost_wait_done)
  );

  lbs_interval u_gate_wait (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(seq_run),
    .limit_i(pos_gate_delay),
    .done_o(gate_wait_done)
  );

  lbs_interval u_short (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(boost_on && s.boost_fb_low),
    .limit_i(lbs_pkg::CNT_W'(SHORT_CYC)),
    .done_o(short_done)
  );

  // gate rail only in run, after second delay
  assign pos_en = (state == lbs_pkg::ST_RUN) && gate_wait_done;

  // positive gate rail short tracking
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !seq_run)
    begin
      pump_passed <= 1'b0;
      pump_armed <= 1'b0;
    end
    else
    begin
      if (pos_en && !s.pump_fb_low)
        pump_passed <= 1'b1;
      if (pos_en && s.pos_gate_in_reg)
        pump_armed <= 1'b1;
    end
  end

  // short blocks boost unless rail passed threshold before good
  assign pump_block = pos_en && s.pump_fb_low && (pump_armed || !pump_passed);
  assign boost_on = (state == lbs_pkg::ST_RUN) && !pump_block;

  // rail enables
  always_comb
  begin
    next_rails.buck = s.buck_enable_in && !s.uvlo;
    next_rails.negative_gate_rail = (state != lbs_pkg::ST_OFF) && bias_ok;
    next_rails.shunt = (state != lbs_pkg::ST_OFF) && bias_ok;
    next_rails.boost_output_rail = boost_on;
    next_rails.positive_gate_rail = pos_en;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rails_o <= '0;
    else
      rails_o <= next_rails;
  end

  // isolation switch gate drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      isolation_gate_drive_o <= 1'b1;
    // low once boost enabled past first delay
    else if (state == lbs_pkg::ST_RUN)
      isolation_gate_drive_o <= 1'b0;
    else
      isolation_gate_drive_o <= 1'b1;
  end

  // power good latch, short clears it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state != lbs_pkg::ST_RUN)
      good_latched <= 1'b0;
    else if (short_done || (pump_armed && s.pump_fb_low))
      good_latched <= 1'b0;
    else if (pos_en && s.boost_in_reg && s.pos_gate_in_reg)
      good_latched <= 1'b1;
  end

  assign power_good_out_o = 1'b0;
  assign power_good_out_oe_n_o = good_latched;

  // stress resistor pin
  // ground while select high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stress_resistor_switch_oe_n_o <= 1'b1;
    else
      stress_resistor_switch_oe_n_o <= !s.stress_test_select;
  end
  assign stress_resistor_switch_o = 1'b0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || pwm_count == lbs_pkg::PWM_CYC - 7'h01)
      pwm_count <= 7'h00;
    else
      pwm_count <= pwm_count + 7'h01;
  end

  // boost switching clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      boost_switch_o <= 1'b0;
    else
      boost_switch_o <= boost_on && !s.overvoltage_sense && !s.boost_fb_over
                        && (pwm_count < lbs_pkg::PWM_HIGH);
  end

  // soft-start current limit ramp
  // ramp until regulation or maximum
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !boost_on)
    begin
      current_limit_o <= '0;
      ss_count <= '0;
      ss_done <= 1'b0;
    end
    else if (s.boost_in_reg || current_limit_o == lbs_pkg::ILIM_MAX)
      ss_done <= 1'b1;
    else if (!ss_done)
    begin
      if (ss_count >= ss_step)
      begin
        ss_count <= '0;
        current_limit_o <= current_limit_o + 1'b1;
      end
      else
        ss_count <= ss_count + 1'b1;
    end
  end

  // wishbone request not yet answered
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // acknowledge one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  // writable timing registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      boost_delay <= lbs_pkg::BOOST_DLY_RST;
      pos_gate_delay <= lbs_pkg::POS_DLY_RST;
      ss_step <= lbs_pkg::SS_STEP_RST;
    end
    else if (wb_req && wb_we_i)
    begin
      case (wb_adr_i)
        lbs_pkg::REG_BOOST_DLY:
          boost_delay <= lane_merge(boost_delay, wb_dat_i, wb_sel_i);
        lbs_pkg::REG_POS_DLY:
          pos_gate_delay <= lane_merge(pos_gate_delay, wb_dat_i, wb_sel_i);
        lbs_pkg::REG_SS_STEP:
          ss_step <= lane_merge(ss_step, wb_dat_i, wb_sel_i);
        default:
          ss_step <= ss_step;
      endcase
    end
  end

  // status word of block state
  assign status_word = {
    3'h0,
    s,
    current_limit_o,
    pump_armed,
    boost_switch_o,
    isolation_gate_drive_o,
    rails_o.positive_gate_rail,
    rails_o.boost_output_rail,
    good_latched,
    state
  };

  // read decode, unmapped reads zero
  always_comb
  begin
    case (wb_adr_i)
      lbs_pkg::REG_BOOST_DLY:
        read_word = {12'h000, boost_delay};
      lbs_pkg::REG_POS_DLY:
        read_word = {12'h000, pos_gate_delay};
      lbs_pkg::REG_SS_STEP:
        read_word = {12'h000, ss_step};
      lbs_pkg::REG_STATUS:
        read_word = status_word;
      default:
        read_word = 32'h0000_0000;
    endcase
  end

  // read data held from the request edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
      wb_dat_o <= read_word;
  end
endmodule

// ==== common/lbs_pkg.sv ====
// constants, register map and carrier types of the lcd bias startup sequencer
package lbs_pkg;
  // clock and counter widths
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1000000;
  localparam int CNT_W = 20;
  localparam int ILIM_W = 8;
  localparam logic [ILIM_W-1:0] ILIM_MAX = 8'hFF;
  // boost switching clock
  localparam int unsigned PWM_HZ = 750000;
  localparam logic [6:0] PWM_CYC = 7'(CLK_HZ / PWM_HZ);
  localparam logic [6:0] PWM_HIGH = 7'(CLK_HZ / PWM_HZ / 2);
  // boost short timer
  localparam int unsigned SHORT_TIME_US = 1400;
  localparam int unsigned SHORT_CYC = SHORT_TIME_US * CLK_MHZ;
  // reset values of the delay and soft-start registers
  localparam int unsigned BOOST_DLY_US = 2500;
  localparam int unsigned POS_DLY_US = 2500;
  localparam int unsigned SS_TIME_US = 900;
  localparam logic [CNT_W-1:0] BOOST_DLY_RST = CNT_W'(BOOST_DLY_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] POS_DLY_RST = CNT_W'(POS_DLY_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] SS_STEP_RST = CNT_W'(SS_TIME_US * CLK_MHZ / 255);
  // register byte offsets
  localparam logic [7:0] REG_BOOST_DLY = 8'h00;
  localparam logic [7:0] REG_POS_DLY = 8'h04;
  localparam logic [7:0] REG_SS_STEP = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  // sequencer states
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10,
    ST_LATCH = 2'b11
  } lbs_state_t;
  // comparator and pin levels from outside the clock domain
  typedef struct packed {
    logic buck_enable_in;
    logic bias_enable_in;
    logic uvlo;
    logic buck_short;
    logic boost_fb_low;
    logic pump_fb_low;
    logic boost_in_reg;
    logic pos_gate_in_reg;
    logic overvoltage_sense;
    logic boost_fb_over;
    logic stress_test_select;
    logic power_good_pin;
    logic stress_pin;
  } lbs_sense_t;
  // rail enables
  typedef struct packed {
    logic buck;
    logic negative_gate_rail;
    logic shunt;
    logic boost_output_rail;
    logic positive_gate_rail;
  } lbs_rails_t;
endpackage

// ==== rtl/lbs_sync.sv ====
// two flip-flop synchroniser for a bank of asynchronous levels
`timescale 1ns/1ps
module lbs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ==== rtl/lbs_interval.sv ====
// saturating interval counter, done once limit cycles have run
`timescale 1ns/1ps
module lbs_interval (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [lbs_pkg::CNT_W-1:0] limit_i,
  output logic done_o
);
  logic [lbs_pkg::CNT_W-1:0] count;

  // counts while run is high, clears when it drops
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
      count <= '0;
    else if (count < limit_i)
      count <= count + 1'b1;
  end

  // a zero limit is done at once
  assign done_o = run_i && (count >= limit_i);
endmodule

// ==== tb/lbs_sequencer_sva.sv ====
// port checker for the lcd bias startup sequencer
`timescale 1ns/1ps
module lbs_sequencer_sva #(
  parameter int unsigned SHORT_CYC = lbs_pkg::SHORT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire lbs_pkg::lbs_sense_t sense_i,
  input wire lbs_pkg::lbs_rails_t rails_o,
  input wire logic boost_switch_o,
  input wire logic isolation_gate_drive_o,
  input wire logic power_good_out_o,
  input wire logic power_good_out_oe_n_o,
  input wire logic stress_resistor_switch_o,
  input wire logic stress_resistor_switch_oe_n_o
);
  logic [7:0] high_run;
  logic [7:0] quiet;
  logic [31:0] low_run;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // length of the running switch high phase
  always_ff @(posedge clk_i)
    high_run <= (rst_i || !boost_switch_o) ? 8'h00 : high_run + 8'h01;
  // cycles free of anything that may cut a switch phase short
  always_ff @(posedge clk_i)
    if (rst_i || sense_i.overvoltage_sense || sense_i.boost_fb_over || sense_i.pump_fb_low
        || sense_i.boost_fb_low || sense_i.uvlo || sense_i.buck_short
        || !sense_i.bias_enable_in || !rails_o.boost_output_rail)
      quiet <= 8'h00;
    else if (quiet != 8'hFF)
      quiet <= quiet + 8'h01;
  // cycles of low boost feedback with the boost rail on
  always_ff @(posedge clk_i)
    low_run <= (rst_i || !sense_i.boost_fb_low || !rails_o.boost_output_rail) ? 32'h0
      : low_run + 32'h1;
  AST_BUCK_ON: assert property (
    (sense_i.buck_enable_in && !sense_i.uvlo) [*4] |-> rails_o.buck) else $error("buck off");
  AST_UVLO_OFF: assert property (
    sense_i.uvlo [*5] |-> rails_o == 5'h00) else $error("rail on in lockout");
  AST_NEG_PAIR: assert property (
    rails_o.negative_gate_rail == rails_o.shunt) else $error("negative rails apart");
  AST_POS_ORDER: assert property (
    $rose(rails_o.positive_gate_rail) |-> rails_o.boost_output_rail) else $error("gate early");
  AST_PG_CAUSE: assert property (
    $rose(power_good_out_oe_n_o) |-> rails_o.boost_output_rail && rails_o.positive_gate_rail
      && sense_i.boost_in_reg && sense_i.pos_gate_in_reg) else $error("power good early");
  AST_PG_LOW: assert property (
    !power_good_out_o && !stress_resistor_switch_o) else $error("pin driven high");
  // a gate rail short stops the boost rail but leaves the isolation switch closed
  AST_GATE_FOLLOW: assert property (
    (!sense_i.pump_fb_low) [*4] ##0 $stable(rails_o.boost_output_rail)
      |-> isolation_gate_drive_o == !rails_o.boost_output_rail)
    else $error("gate drive wrong");
  AST_SHORT_TRIP: assert property (
    low_run < 32'(SHORT_CYC + 6)) else $error("boost short not tripped");
  AST_STRESS: assert property (
    sense_i.stress_test_select [*4] |-> !stress_resistor_switch_oe_n_o) else $error("stress pin");
  AST_OV_STOP: assert property (
    sense_i.overvoltage_sense [*4] |-> !boost_switch_o) else $error("switching in overvoltage");
  AST_FB_OVER_STOP: assert property (
    sense_i.boost_fb_over [*4] |-> !boost_switch_o) else $error("switching over level");
  AST_PWM_HIGH: assert property (
    $fell(boost_switch_o) && quiet > 8'd100 |-> high_run == {1'b0, lbs_pkg::PWM_HIGH})
    else $error("switch phase length");
  // main scenarios reached
  cover property ($rose(power_good_out_oe_n_o));
  cover property ($rose(boost_switch_o));
  cover property ($fell(rails_o.boost_output_rail) && low_run > 32'h0);
endmodule
bind lbs_sequencer lbs_sequencer_sva #(.SHORT_CYC(SHORT_CYC)) u_lbs_sequencer_sva (
  .clk_i(clk_i), .rst_i(rst_i), .sense_i(sense_i), .rails_o(rails_o),
  .boost_switch_o(boost_switch_o), .isolation_gate_drive_o(isolation_gate_drive_o),
  .power_good_out_o(power_good_out_o), .power_good_out_oe_n_o(power_good_out_oe_n_o),
  .stress_resistor_switch_o(stress_resistor_switch_o),
  .stress_resistor_switch_oe_n_o(stress_resistor_switch_oe_n_o));

// ==== tb/lbs_panel_model.sv ====
// far-side model of the panel rails, feedback levels and pull-ups
`timescale 1ns/1ps
module lbs_panel_model #(
  parameter int RAMP = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // rails and open-drain pins from the sequencer
  input wire lbs_pkg::lbs_rails_t rails_i,
  input wire logic good_i,
  input wire logic good_oe_n_i,
  input wire logic stress_i,
  input wire logic stress_oe_n_i,
  // faults: lost regulation, pump short, boost short
  input wire logic [2:0] fault_i,
  // feedback levels and pin levels
  output logic boost_fb_low_o,
  output logic pump_fb_low_o,
  output logic boost_in_reg_o,
  output logic pos_in_reg_o,
  output logic good_pin_o,
  output logic stress_pin_o
);
  int boost_age;
  int pos_age;
  // rails build up over several cycles after each enable
  always_ff @(posedge clk_i)
  begin
    boost_age <= (rst_i || !rails_i.boost_output_rail) ? 0 : boost_age + 1;
    pos_age <= (rst_i || !rails_i.positive_gate_rail) ? 0 : pos_age + 1;
  end
  // comparator levels seen by the sequencer
  assign boost_fb_low_o = boost_age < 4 || fault_i[0];
  assign pump_fb_low_o = fault_i[1];
  assign boost_in_reg_o = boost_age >= RAMP && fault_i == 3'h0;
  assign pos_in_reg_o = pos_age >= RAMP && fault_i == 3'h0;
  assign good_pin_o = good_oe_n_i ? 1'b1 : good_i;
  assign stress_pin_o = stress_oe_n_i ? 1'b1 : stress_i;
endmodule

// ==== tb/test_lcd_bias_startup_sequencer.sv ====
// self-checking bench for the lcd bias startup sequencer
`timescale 1ns/1ps
module test_lcd_bias_startup_sequencer;
  localparam int SC = 50;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o;
  logic buck_en = 1'b0, bias_en = 1'b0, uvlo = 1'b0, bshort = 1'b0, ov = 1'b0, fbo = 1'b0;
  logic stress = 1'b0;
  logic [2:0] fault = 3'h0;
  logic fb_low, pump_low, boost_reg, pos_reg, good_pin, st_pin;
  logic sw, iso_gate, good_o, good_oe_n, st_o, st_oe_n;
  logic [7:0] ilim;
  lbs_pkg::lbs_sense_t sense_i;
  lbs_pkg::lbs_rails_t rails_o;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  // comparator bundle in package order
  assign sense_i = {buck_en, bias_en, uvlo, bshort, fb_low, pump_low, boost_reg, pos_reg, ov,
    fbo, stress, good_pin, st_pin};
  lbs_sequencer #(.SHORT_CYC(SC)) u_lbs_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sense_i(sense_i), .rails_o(rails_o), .boost_switch_o(sw),
    .current_limit_o(ilim), .isolation_gate_drive_o(iso_gate), .power_good_out_o(good_o),
    .power_good_out_oe_n_o(good_oe_n), .stress_resistor_switch_o(st_o),
    .stress_resistor_switch_oe_n_o(st_oe_n));
  lbs_panel_model u_lbs_panel_model (
    .clk_i(clk_i), .rst_i(rst_i), .rails_i(rails_o), .good_i(good_o),
    .good_oe_n_i(good_oe_n), .stress_i(st_o), .stress_oe_n_i(st_oe_n), .fault_i(fault),
    .boost_fb_low_o(fb_low), .pump_fb_low_o(pump_low), .boost_in_reg_o(boost_reg),
    .pos_in_reg_o(pos_reg), .good_pin_o(good_pin), .stress_pin_o(st_pin));
  // 50 MHz clock
  initial
    forever #10 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one classic wishbone cycle, read data left in q
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return rails_o.boost_output_rail;
      1: return rails_o.positive_gate_rail;
      2: return rails_o.negative_gate_rail;
      3: return good_oe_n;
      default: return sw;
    endcase
  endfunction
  // cycles until an output reaches a level
  task automatic wait_on(input int s, input logic v, output int k);
    k = 0;
    while (pick(s) !== v && k < 3000)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask
  // one bias start with given delays, faults on the first run
  task automatic run_seq(input int d, input int p, input bit full);
    int nb;
    int np;
    int mx;
    logic [7:0] lim;
    logic seen;
    mx = (d > p) ? d : p;
    xfer(1'b1, lbs_pkg::REG_BOOST_DLY, 32'(d));
    xfer(1'b1, lbs_pkg::REG_POS_DLY, 32'(p));
    bias_en <= 1'b1;
    wait_on(2, 1'b1, n);
    chk(rails_o.shunt, 1, "shunt rail");
    wait_on(0, 1'b1, nb);
    wait_on(1, 1'b1, np);
    chk(nb >= d && nb <= d + 1, 1, "boost delay");
    chk(nb + np >= mx && nb + np <= mx + 1, 1, "gate rail delay");
    chk(d != p || np == 0, 1, "rails together");
    chk(iso_gate, 0, "gate drive on");
    wait_on(3, 1'b1, n);
    repeat (4) @(posedge clk_i);
    lim = ilim;
    chk(lim != 8'h00 && good_pin, 1, "power good");
    repeat (20) @(posedge clk_i);
    chk(ilim, lim, "limit frozen");
    if (full)
    begin
      fault <= 3'b100;
      repeat (10) @(posedge clk_i);
      chk(good_oe_n, 1, "power good held");
      fault <= 3'b000;
      for (int k = 0; k < 3; k++)
      begin
        {ov, fbo, fault[1]} <= 3'b100 >> k;
        repeat (6) @(posedge clk_i);
        seen = 1'b0;
        repeat (100)
        begin
          @(posedge clk_i);
          seen |= sw;
        end
        chk(seen, 0, "switching stopped");
        {ov, fbo, fault[1]} <= 3'b000;
        wait_on(4, 1'b1, n);
        chk(n < 200, 1, "switching resumed");
      end
      // let the start-up low feedback clear so the short timer starts from zero
      repeat (10) @(posedge clk_i);
      fault <= 3'b001;
      wait_on(0, 1'b0, n);
      chk(n >= SC && n <= SC + 6, 1, "short trip time");
      chk({iso_gate, good_oe_n}, 2'b10, "short shutdown");
      fault <= 3'b000;
      repeat (100) @(posedge clk_i);
      chk(rails_o.boost_output_rail, 0, "no self recovery");
      xfer(1'b0, lbs_pkg::REG_STATUS, 32'h0);
      chk(q[5:0], 6'h23, "latch status");
    end
    bias_en <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(rails_o, 5'h10, "bias off");
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({rails_o, iso_gate, good_oe_n, st_oe_n, ilim}, {5'h00, 3'b101, 8'h00}, "reset");
    xfer(1'b0, lbs_pkg::REG_BOOST_DLY, 32'h0);
    chk(q, 32'(lbs_pkg::BOOST_DLY_RST), "delay reset value");
    xfer(1'b1, 8'h10, 32'hFFFFFFFF);
    xfer(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0, "unmapped read");
    xfer(1'b1, lbs_pkg::REG_SS_STEP, 32'h2);
    $display("test done: reset and registers");
    buck_en <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(rails_o, 5'h10, "buck alone");
    run_seq(20, 40, 1'b1);
    run_seq(30, 5, 1'b0);
    run_seq(0, 0, 1'b0);
    $display("test done: sequencing");
    stress <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({st_oe_n, st_pin}, 2'b00, "stress grounded");
    stress <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({st_oe_n, st_pin}, 2'b11, "stress released");
    bias_en <= 1'b1;
    wait_on(3, 1'b1, n);
    bshort <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({rails_o, good_oe_n}, 6'h20, "buck short");
    bshort <= 1'b0;
    wait_on(3, 1'b1, n);
    chk(rails_o, 5'h1F, "restart");
    uvlo <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(rails_o, 5'h00, "lockout");
    $display("test done: protection");
    final_report();
  end
endmodule
